// ---- hdl/arith_pkg.sv ----
package arith_pkg;

  localparam int unsigned DATA_W  = 16;
  localparam int unsigned ACC_W   = 32;
  localparam int unsigned SHAMT_W = 5;
  localparam int unsigned BIT_W   = 4;
  localparam int unsigned PRE_W   = 4;
  localparam int unsigned OSH_W   = 3;

  localparam logic [SHAMT_W-1:0] SHIFT_MAX = 5'h10;

  localparam logic [ACC_W-1:0] SAT_POS = 32'h7FFF_FFFF;
  localparam logic [ACC_W-1:0] SAT_NEG = 32'h8000_0000;

  localparam logic [1:0] PSHIFT_NONE = 2'h0;
  localparam logic [1:0] PSHIFT_L1   = 2'h1;
  localparam logic [1:0] PSHIFT_L4   = 2'h2;
  localparam logic [1:0] PSHIFT_R6   = 2'h3;
  localparam int unsigned PSH_L1_AMT = 1;
  localparam int unsigned PSH_L4_AMT = 4;
  localparam int unsigned PSH_R6_AMT = 6;

  localparam logic [3:0] REG_ACC_HI  = 4'h0;
  localparam logic [3:0] REG_ACC_LO  = 4'h1;
  localparam logic [3:0] REG_PROD_HI = 4'h2;
  localparam logic [3:0] REG_PROD_LO = 4'h3;
  localparam logic [3:0] REG_FACTOR  = 4'h4;
  localparam logic [3:0] REG_SHAMT   = 4'h5;
  localparam logic [3:0] REG_BITIDX  = 4'h6;
  localparam logic [3:0] REG_MASK    = 4'h7;
  localparam logic [3:0] REG_ST0     = 4'h8;
  localparam logic [3:0] REG_ST1     = 4'h9;
  localparam logic [3:0] REG_MODE    = 4'hA;
  localparam logic [3:0] REG_SAVE_HI = 4'hB;
  localparam logic [3:0] REG_SAVE_LO = 4'hC;

  // Status and mode bit positions.
  localparam int unsigned ST0_OV_BIT  = 12;
  localparam int unsigned ST0_OVM_BIT = 11;
  localparam int unsigned ST1_C_BIT   = 9;
  localparam int unsigned ST1_SXM_BIT = 10;
  localparam int unsigned ST1_TC_BIT  = 11;
  localparam int unsigned ST1_PM_LSB  = 0;
  localparam int unsigned MODE_TRM_BIT = 0;

  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_ADD   = 4'h1,
    OP_SUB   = 4'h2,
    OP_LOAD  = 4'h3,
    OP_AND   = 4'h4,
    OP_OR    = 4'h5,
    OP_XOR   = 4'h6,
    OP_MAC   = 4'h7,
    OP_MPY   = 4'h8,
    OP_RSHR  = 4'h9,
    OP_DYNAMIC_BIT_TEST_OPCODE  = 4'hA,
    OP_TLOAD = 4'hB,
    OP_LOGIC = 4'hC,
    OP_SAVE  = 4'hD
  } op_t;

  typedef enum logic [1:0] {
    LOP_AND = 2'h0,
    LOP_OR  = 2'h1,
    LOP_XOR = 2'h2,
    LOP_TST = 2'h3
  } lop_t;

  typedef struct packed {
    logic              valid;
    op_t               op;
    lop_t              lop;
    logic [DATA_W-1:0] data;
    logic              use_dyn;
    logic [SHAMT_W-1:0] shamt;
    logic              use_imm;
    logic [DATA_W-1:0] imm;
    logic [OSH_W-1:0]  out_shift;
  } instr_t;

  typedef struct packed {
    logic [3:0]        addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage : arith_pkg

// ---- hdl/dsp_core_arith_datapath.sv ----
`timescale 1ns/1ps
module dsp_core_arith_datapath (
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  input  wire arith_pkg::instr_t         instr,
  input  wire arith_pkg::reg_req_t       reg_req,
  output logic [arith_pkg::DATA_W-1:0]   reg_rdata,
  output logic [arith_pkg::DATA_W-1:0]   store_data,
  output logic [arith_pkg::DATA_W-1:0]   logic_result,
  output logic                           logic_valid
);
  import arith_pkg::*;

  function automatic logic [ACC_W-1:0] extend(input logic [DATA_W-1:0] v, input logic sx);
    extend = {{DATA_W{sx & v[DATA_W-1]}}, v};
  endfunction : extend

  logic [ACC_W-1:0]  acc_q, acc_d, save_q, save_d, prod_q, prod_d;
  logic [DATA_W-1:0] factor_q, factor_d, mask_q, mask_d;
  logic [SHAMT_W-1:0] shamt_q, shamt_d;
  logic [BIT_W-1:0]  bitidx_q, bitidx_d;
  logic [PRE_W-1:0]  pre_q, pre_d;
  logic              ov_q, ov_d, ovm_q, ovm_d, c_q, c_d, sxm_q, sxm_d, tc_q, tc_d, trm_q, trm_d;
  logic [1:0]        pm_q, pm_d;
  logic [DATA_W-1:0] rdata_d, store_d, lres_d, mask_opd, st0_w, st1_w;
  logic              lvalid_d;
  logic [ACC_W-1:0]  shifted, pshift, alu_b, sum, prod_full;
  logic [ACC_W:0]    wide;
  logic [4:0]        amt;
  logic              ovf;

  // Status words are assembled bit by bit so that no shift of a one-bit flag can lose its value.
  always_comb begin
    st0_w                  = '0;
    st0_w[ST0_OV_BIT]      = ov_q;
    st0_w[ST0_OVM_BIT]     = ovm_q;
    st1_w                  = '0;
    st1_w[ST1_C_BIT]       = c_q;
    st1_w[ST1_SXM_BIT]     = sxm_q;
    st1_w[ST1_TC_BIT]      = tc_q;
    st1_w[ST1_PM_LSB +: 2] = pm_q;
  end

  always_comb begin
    amt     = instr.use_dyn ? shamt_q : instr.shamt;
    // Shift counts above 16 are clamped so the shifter stays within its range.
    if (amt > SHIFT_MAX) begin
      amt = SHIFT_MAX;
    end
    shifted = extend(instr.data, sxm_q) << amt;
    prod_full = extend(factor_q, 1'b1) * extend(instr.data, 1'b1);
    case (pm_q)
      PSHIFT_L1: pshift = prod_q << PSH_L1_AMT;
      PSHIFT_L4: pshift = prod_q << PSH_L4_AMT;
      PSHIFT_R6: pshift = ACC_W'($signed(prod_q) >>> PSH_R6_AMT);
      default:   pshift = prod_q;
    endcase
    case (instr.op)
      OP_SUB:  alu_b = ~shifted;
      OP_MAC:  alu_b = pshift;
      default: alu_b = shifted;
    endcase
    wide = {1'b0, acc_q} + {1'b0, alu_b} + {{ACC_W{1'b0}}, instr.op == OP_SUB};
    sum  = wide[ACC_W-1:0];
    ovf  = (acc_q[ACC_W-1] == alu_b[ACC_W-1]) && (sum[ACC_W-1] != acc_q[ACC_W-1]);
    mask_opd = instr.use_imm ? instr.imm : mask_q;
    acc_d    = acc_q;
    save_d   = save_q;
    prod_d   = prod_q;
    factor_d = factor_q;
    mask_d   = mask_q;
    shamt_d  = shamt_q;
    bitidx_d = bitidx_q;
    pre_d    = pre_q;
    ov_d     = ov_q;
    ovm_d    = ovm_q;
    c_d      = c_q;
    sxm_d    = sxm_q;
    tc_d     = tc_q;
    trm_d    = trm_q;
    pm_d     = pm_q;
    lres_d   = logic_result;
    lvalid_d = 1'b0;
    store_d  = store_data;
    if (instr.valid) begin
      case (instr.op)
        OP_ADD, OP_SUB, OP_MAC: begin
          pre_d = amt[PRE_W-1:0];
          c_d = wide[ACC_W];
          if (ovf) begin
            ov_d = 1'b1;
            acc_d = ovm_q ? (acc_q[ACC_W-1] ? SAT_NEG : SAT_POS) : sum;
          end else begin
            acc_d = sum;
          end
        end
        OP_LOAD: acc_d = shifted;
        OP_AND:  acc_d = acc_q & shifted;
        OP_OR:   acc_d = acc_q | shifted;
        OP_XOR:  acc_d = acc_q ^ shifted;
        OP_MPY:  prod_d = prod_full;
        OP_RSHR: acc_d = sxm_q ? ACC_W'($signed(acc_q) >>> amt) : acc_q >> amt;
        OP_SAVE: save_d = acc_q;
        OP_DYNAMIC_BIT_TEST_OPCODE: begin
          pre_d = instr.use_dyn ? bitidx_q : instr.shamt[BIT_W-1:0];
          tc_d  = instr.data[instr.use_dyn ? bitidx_q : instr.shamt[BIT_W-1:0]];
        end
        OP_TLOAD: begin
          factor_d = instr.data;
          if (trm_q) begin
            shamt_d  = instr.data[SHAMT_W-1:0];
            bitidx_d = instr.data[BIT_W-1:0];
          end
        end
        OP_LOGIC: begin
          lvalid_d = 1'b1;
          case (instr.lop)
            LOP_AND: lres_d = instr.data & mask_opd;
            LOP_OR:  lres_d = instr.data | mask_opd;
            LOP_XOR: lres_d = instr.data ^ mask_opd;
            default: begin
              lres_d = instr.data;
              tc_d   = (instr.data & mask_opd) == mask_opd;
            end
          endcase
        end
        default: store_d = DATA_W'(acc_q[ACC_W-1:DATA_W] << instr.out_shift);
      endcase
    end
    if (reg_req.wr) begin
      case (reg_req.addr)
        REG_ACC_HI:  acc_d[ACC_W-1:DATA_W]  = reg_req.wdata;
        REG_ACC_LO:  acc_d[DATA_W-1:0]      = reg_req.wdata;
        REG_PROD_HI: prod_d[ACC_W-1:DATA_W] = reg_req.wdata;
        REG_PROD_LO: prod_d[DATA_W-1:0]     = reg_req.wdata;
        REG_FACTOR:  factor_d = reg_req.wdata;
        REG_SHAMT:   shamt_d  = reg_req.wdata[SHAMT_W-1:0];
        REG_BITIDX:  bitidx_d = reg_req.wdata[BIT_W-1:0];
        REG_MASK:    mask_d   = reg_req.wdata;
        REG_ST0: begin
          ov_d  = reg_req.wdata[ST0_OV_BIT] | (ov_d & ~ov_q);
          ovm_d = reg_req.wdata[ST0_OVM_BIT];
        end
        REG_ST1: begin
          c_d   = reg_req.wdata[ST1_C_BIT];
          sxm_d = reg_req.wdata[ST1_SXM_BIT];
          tc_d  = reg_req.wdata[ST1_TC_BIT];
          pm_d  = reg_req.wdata[ST1_PM_LSB +: 2];
        end
        REG_MODE:    trm_d = reg_req.wdata[MODE_TRM_BIT];
        REG_SAVE_HI: save_d[ACC_W-1:DATA_W] = reg_req.wdata;
        REG_SAVE_LO: save_d[DATA_W-1:0]     = reg_req.wdata;
        default: ;
      endcase
    end
    rdata_d = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        REG_ACC_HI:  rdata_d = acc_q[ACC_W-1:DATA_W];
        REG_ACC_LO:  rdata_d = acc_q[DATA_W-1:0];
        REG_PROD_HI: rdata_d = prod_q[ACC_W-1:DATA_W];
        REG_PROD_LO: rdata_d = prod_q[DATA_W-1:0];
        REG_FACTOR:  rdata_d = factor_q;
        REG_SHAMT:   rdata_d = DATA_W'(shamt_q);
        REG_BITIDX:  rdata_d = DATA_W'(bitidx_q);
        REG_MASK:    rdata_d = mask_q;
        REG_ST0:     rdata_d = st0_w;
        REG_ST1:     rdata_d = st1_w;
        REG_MODE:    rdata_d = {pre_q, 11'h000, trm_q};
        REG_SAVE_HI: rdata_d = save_q[ACC_W-1:DATA_W];
        REG_SAVE_LO: rdata_d = save_q[DATA_W-1:0];
        default:     rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      acc_q        <= '0;
      save_q       <= '0;
      prod_q       <= '0;
      factor_q     <= '0;
      mask_q       <= '0;
      shamt_q      <= '0;
      bitidx_q     <= '0;
      pre_q        <= '0;
      ov_q         <= 1'b0;
      ovm_q        <= 1'b0;
      c_q          <= 1'b0;
      sxm_q        <= 1'b1;
      tc_q         <= 1'b0;
      trm_q        <= 1'b1;
      pm_q         <= '0;
      reg_rdata    <= '0;
      store_data   <= '0;
      logic_result <= '0;
      logic_valid  <= 1'b0;
    end else begin
      acc_q        <= acc_d;
      save_q       <= save_d;
      prod_q       <= prod_d;
      factor_q     <= factor_d;
      mask_q       <= mask_d;
      shamt_q      <= shamt_d;
      bitidx_q     <= bitidx_d;
      pre_q        <= pre_d;
      ov_q         <= ov_d;
      ovm_q        <= ovm_d;
      c_q          <= c_d;
      sxm_q        <= sxm_d;
      tc_q         <= tc_d;
      trm_q        <= trm_d;
      pm_q         <= pm_d;
      reg_rdata    <= rdata_d;
      store_data   <= store_d;
      logic_result <= lres_d;
      logic_valid  <= lvalid_d;
    end
  end

  a_ovf_sets_flag: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_ADD && ovf && !reg_req.wr |=> ov_q)
    else $error("overflow did not set flag");
  a_sat_positive: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_ADD && ovf && ovm_q && !acc_q[ACC_W-1] && !reg_req.wr |=> acc_q == SAT_POS)
    else $error("saturation value wrong");
  a_tload_single: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_TLOAD && !trm_q && !reg_req.wr |=> $stable(shamt_q) && factor_q == $past(instr.data))
    else $error("temp load wrote wrong holders");
  a_logic_keeps_acc: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_LOGIC && !reg_req.wr |=> $stable(acc_q) && logic_valid)
    else $error("logic op touched result register");
  a_read_latency: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.rd && reg_req.addr == REG_PROD_HI && !reg_req.wr |=> reg_rdata == $past(prod_q[ACC_W-1:DATA_W]))
    else $error("product high read wrong");
  a_carry_capture: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_ADD && !reg_req.wr |=> c_q == $past(wide[ACC_W]))
    else $error("carry not captured");
  a_load_shift: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_LOAD && !sxm_q && !reg_req.wr |=> acc_q == ($past(extend(instr.data, 1'b0)) << $past(amt)))
    else $error("input shift wrong");
  // Three behaviours are described as named single-cycle issue sequences, then checked one cycle later.
  sequence s_mac_r6;
    instr.valid && instr.op == OP_MAC && pm_q == PSHIFT_R6 && !ovf && !reg_req.wr;
  endsequence
  sequence s_sat_neg;
    instr.valid && instr.op == OP_SUB && ovf && ovm_q && acc_q[ACC_W-1] && !reg_req.wr;
  endsequence
  sequence s_dyn_bit_test;
    instr.valid && instr.op == OP_DYNAMIC_BIT_TEST_OPCODE && instr.use_dyn && !reg_req.wr;
  endsequence

  a_pshift_r6: assert property (@(posedge core_clk) disable iff (!resetn)
    s_mac_r6 |=> acc_q == $past(acc_q) + ACC_W'($signed($past(prod_q)) >>> PSH_R6_AMT))
    else $error("product shift wrong");

  a_sat_negative: assert property (@(posedge core_clk) disable iff (!resetn)
    s_sat_neg |=> acc_q == SAT_NEG)
    else $error("negative saturation value wrong");

  a_wrap_excess: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_ADD && !ovm_q && !reg_req.wr |=> acc_q == $past(acc_q) + $past(shifted))
    else $error("wrapping add wrong");

  a_sub_result: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_SUB && !ovm_q && !reg_req.wr |=> acc_q == $past(acc_q) - $past(shifted))
    else $error("subtract result wrong");

  a_out_shift: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_NOP |=>
      store_data == DATA_W'($past(acc_q[ACC_W-1:DATA_W]) << $past(instr.out_shift)))
    else $error("output shift wrong");

  a_shamt_write: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == REG_SHAMT |=> shamt_q == $past(reg_req.wdata[SHAMT_W-1:0]))
    else $error("shift amount write wrong");

  a_bitidx_write: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == REG_BITIDX |=> bitidx_q == $past(reg_req.wdata[BIT_W-1:0]))
    else $error("bit index write wrong");

  a_prescale_dynamic_bit_test_opcode: assert property (@(posedge core_clk) disable iff (!resetn)
    s_dyn_bit_test |=> pre_q == $past(bitidx_q))
    else $error("prescale amount wrong");

  a_test_flag: assert property (@(posedge core_clk) disable iff (!resetn)
    s_dyn_bit_test |=> tc_q == (($past(instr.data) & (DATA_W'(1) << $past(bitidx_q))) != '0))
    else $error("bit test flag wrong");

  a_mpy_product: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_MPY && !reg_req.wr |=>
      $signed(prod_q) == $signed($past(factor_q)) * $signed($past(instr.data)))
    else $error("product wrong");

  a_sign_extend: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_LOAD && sxm_q && !reg_req.wr |=>
      acc_q == ({{DATA_W{$past(instr.data[DATA_W-1])}}, $past(instr.data)} << $past(amt)))
    else $error("sign extension wrong");

  a_logic_mask: assert property (@(posedge core_clk) disable iff (!resetn)
    instr.valid && instr.op == OP_LOGIC && instr.lop == LOP_AND && !instr.use_imm |=>
      logic_result == ($past(instr.data) & $past(mask_q)))
    else $error("mask operand wrong");

  a_acc_halves: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == REG_ACC_LO && !instr.valid |=>
      acc_q[DATA_W-1:0] == $past(reg_req.wdata) && acc_q[ACC_W-1:DATA_W] == $past(acc_q[ACC_W-1:DATA_W]))
    else $error("result half write wrong");

  a_flags_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    !instr.valid && !reg_req.wr |=> $stable(ov_q) && $stable(c_q) && $stable(tc_q))
    else $error("flag changed without instruction");

endmodule : dsp_core_arith_datapath

// ---- bench/core_decode_model.sv ----
`timescale 1ns/1ps
module core_decode_model (
  input  wire logic           core_clk,
  output arith_pkg::instr_t   instr,
  output arith_pkg::reg_req_t reg_req,
  input  wire logic [15:0]    reg_rdata
);
  import arith_pkg::*;
  // Released address and data fields carry inverted values, with strobes and valid cleared, so that a stale operand is never mistaken for a live one.
  initial begin
    instr   = '0;
    reg_req = '0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    reg_req <= '{~a, ~d, 1'b0, 1'b0};
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    reg_req <= '{~a, 16'hFFFF, 1'b0, 1'b0};
    #1 d = reg_rdata;
  endtask : rd
  task automatic exec(input instr_t i);
    @(posedge core_clk);
    instr <= i;
    @(posedge core_clk);
    i.valid = 1'b0;
    i.data  = ~i.data;
    instr <= i;
  endtask : exec
endmodule : core_decode_model

// ---- bench/test_dsp_core_arith_datapath.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module test_dsp_core_arith_datapath;
  import arith_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  instr_t      instr;
  reg_req_t    reg_req;
  logic [15:0] reg_rdata;
  logic [15:0] store_data;
  logic [15:0] logic_result;
  logic        logic_valid;
  logic [31:0] seed      = 32'h0000_76ca;
  int          bad_count = 0;
  int          checked   = 0;
  always #20 core_clk = ~core_clk;
  dsp_core_arith_datapath i_dut (.core_clk(core_clk), .resetn(resetn), .instr(instr), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .store_data(store_data), .logic_result(logic_result), .logic_valid(logic_valid));
  core_decode_model i_feed (.core_clk(core_clk), .instr(instr), .reg_req(reg_req), .reg_rdata(reg_rdata));
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd
  function automatic logic [31:0] xs(logic [15:0] d, logic [4:0] s, logic sx);
    logic [31:0] e;
    e = sx ? {{16{d[15]}}, d} : {16'h0000, d};
    return e << s;
  endfunction : xs
  function automatic logic [31:0] ps(logic [31:0] p, logic [1:0] m);
    case (m)
      2'h1: return p << 1;
      2'h2: return p << 4;
      2'h3: return $signed(p) >>> 6;
      default: return p;
    endcase
  endfunction : ps
  function automatic instr_t mk(op_t o, logic [15:0] d, logic [4:0] s);
    instr_t i;
    i = '0;
    i.valid = 1'b1;
    i.op = o;
    i.data = d;
    i.shamt = s;
    return i;
  endfunction : mk
  task automatic chk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] r;
    i_feed.rd(a, r);
    `CHK(r, e)
  endtask : chk
  task automatic wrchk(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
    i_feed.wr(a, d);
    chk(a, e);
  endtask : wrchk
  task automatic rd32(input logic [3:0] a, output logic [31:0] v);
    i_feed.rd(a, v[31:16]);
    i_feed.rd(a + 4'h1, v[15:0]);
  endtask : rd32
  task automatic conclude();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    conclude();
  end
  initial begin
    logic [15:0] d, m, v, o, r;
    logic [31:0] a, p;
    logic [4:0]  s;
    logic        tc;
    instr_t      i;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    chk(REG_ST1, 16'h0400);
    chk(REG_MODE, 16'h0001);
    wrchk(REG_SHAMT, 16'hFFFF, 16'h001F);
    wrchk(REG_BITIDX, 16'hFFFF, 16'h000F);
    d = rnd();
    wrchk(REG_FACTOR, d, d);
    wrchk(REG_MASK, ~d, ~d);
    wrchk(REG_PROD_LO, d, d);
    wrchk(4'hD, 16'h1234, 16'h0000);
    $display("registers done");
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      m = rnd();
      p = $signed(d) * $signed(m);
      i_feed.wr(REG_FACTOR, d);
      i_feed.wr(REG_ST1, {14'h0100, k[1:0]});
      i_feed.wr(REG_ACC_HI, 16'h0000);
      i_feed.wr(REG_ACC_LO, 16'h0000);
      i_feed.exec(mk(OP_MPY, m, 5'd0));
      rd32(REG_PROD_HI, a);
      `CHK(a, p)
      i_feed.exec(mk(OP_MAC, m, 5'd0));
      rd32(REG_ACC_HI, a);
      `CHK(a, ps(p, k[1:0]))
    end
    $display("product done");
    for (int k = 0; k < 6; k++) begin
      instr_t i;
      d = rnd();
      s = (k == 0) ? 5'd16 : (k[0] ? 5'(rnd() % 16) : 5'(rnd() % 17));
      i = mk(OP_LOAD, d, k[0] ? 5'd0 : s);
      i.use_dyn = k[0];
      i_feed.wr(REG_SHAMT, {11'h000, s});
      i_feed.wr(REG_ST1, {5'h00, k[1], 10'h000});
      i_feed.exec(i);
      rd32(REG_ACC_HI, a);
      `CHK(a, xs(d, s, k[1]))
    end
    $display("shifter done");
    for (int k = 0; k < 4; k++) begin
      i_feed.wr(REG_ST0, {4'h0, k[0], 11'h000});
      i_feed.wr(REG_ACC_HI, k[1] ? 16'h8000 : 16'h7FFF);
      i_feed.wr(REG_ACC_LO, k[1] ? 16'h0000 : 16'hFFFF);
      i_feed.exec(mk(k[1] ? OP_SUB : OP_ADD, 16'h0001, 5'd0));
      rd32(REG_ACC_HI, a);
      `CHK(a, k[0] ? (k[1] ? SAT_NEG : SAT_POS) : (k[1] ? 32'h7FFF_FFFF : 32'h8000_0000))
      chk(REG_ST0, {3'h0, 1'b1, k[0], 11'h000});
    end
    i_feed.wr(REG_ACC_HI, 16'hFFFF);
    i_feed.wr(REG_ACC_LO, 16'hFFFF);
    i_feed.exec(mk(OP_ADD, 16'h0001, 5'd0));
    chk(REG_ST1, 16'h0200);
    d = rnd();
    i_feed.exec(mk(OP_TLOAD, d, 5'd0));
    chk(REG_BITIDX, {12'h000, d[3:0]});
    i_feed.wr(REG_MODE, 16'h0000);
    m = rnd();
    i_feed.exec(mk(OP_TLOAD, m, 5'd0));
    chk(REG_FACTOR, m);
    chk(REG_SHAMT, {11'h000, d[4:0]});
    $display("alu done");
    i_feed.wr(REG_ACC_HI, 16'h1234);
    i_feed.wr(REG_ACC_LO, 16'h5678);
    for (int k = 0; k < 8; k++) begin
      instr_t i;
      d = rnd();
      m = rnd();
      v = (k == 7) ? d & rnd() : rnd();
      o = k[2] ? v : m;
      tc = ((d & o) == o);
      i = mk(OP_LOGIC, d, 5'd0);
      i.lop = lop_t'(k[1:0]);
      i.use_imm = k[2];
      i.imm = v;
      i_feed.wr(REG_MASK, m);
      i_feed.exec(i);
      #1;
      `CHK(logic_valid, 1'b1)
      if (k[1:0] == 2'h3) begin
        i_feed.rd(REG_ST1, r);
        `CHK(r[11], tc)
      end else begin
        `CHK(logic_result, k[1] ? d ^ o : (k[0] ? d | o : d & o))
      end
    end
    rd32(REG_ACC_HI, a);
    `CHK(a, 32'h1234_5678)
    i = mk(OP_NOP, 16'h0000, 5'd0);
    i.out_shift = 3'd3;
    i_feed.exec(i);
    #1;
    `CHK(store_data, 16'h91A0)
    $display("logic done");
    i_feed.wr(REG_BITIDX, 16'h0005);
    i = mk(OP_DYNAMIC_BIT_TEST_OPCODE, 16'h0020, 5'd0);
    i.use_dyn = 1'b1;
    i_feed.exec(i);
    chk(REG_ST1, 16'h0A00);
    chk(REG_MODE, 16'h5000);
    $display("bit test done");
    conclude();
  end
endmodule : test_dsp_core_arith_datapath
